// File: core/fpc_host.sv
// Flash host controller: command issue and completion polling, AXI4-Lite registers
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_host #(
	parameter logic [23:0] POLL_LIMIT_US = 24'(`FPC_CHIP_ERASE_US),
	parameter logic [7:0] US_DIV = 8'(`FPC_CYC(`FPC_T_US_NS))
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Flash pins
	output logic [19:0] flash_addr,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe_n,
	input wire logic [15:0] flash_dq_i,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	// Interrupt
	output logic irq
);
	import fpc_pkg::*;

	logic wr_en;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic cyc_done;
	logic [15:0] cyc_rdata;
	fpc_pins_s pins;

	fpc_seq_e st_q, st_d;
	fpc_op_e op_q, op_d;
	logic [19:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic cyc_start_q, cyc_start_d, cyc_read_q, cyc_read_d;
	logic [19:0] cyc_addr_q, cyc_addr_d;
	logic [15:0] cyc_wdata_q, cyc_wdata_d;
	logic have_prev_q, have_prev_d, prev_alt_q, prev_alt_d;
	logic [15:0] poll_cnt_q, poll_cnt_d;
	logic timeout_q, timeout_d;
	logic [1:0] istat_q, istat_d, imask_q, imask_d;
	logic irq_q, irq_d;
	logic [7:0] div_q, div_d;
	logic [23:0] us_q, us_d;
	logic tick, ev_done, ev_tmo, poll_mode;

	fpc_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	fpc_bus_cycle u_cyc (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(cyc_start_q),
		.is_read(cyc_read_q),
		.addr(cyc_addr_q),
		.wdata(cyc_wdata_q),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.pins(pins),
		.dq_i(flash_dq_i)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// ==========================================
	// Register read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_addr)
			`FPC_REG_CTRL: rd_data[`FPC_CTRL_OP_LO +: 3] = op_q;
			`FPC_REG_ADDR: rd_data[19:0] = addr_q;
			`FPC_REG_WDATA: rd_data[15:0] = wdata_q;
			`FPC_REG_RDATA: rd_data[15:0] = rdata_q;
			`FPC_REG_STATUS: begin
				rd_data[`FPC_ST_BUSY] = (st_q != FPC_SEQ_IDLE);
				rd_data[`FPC_ST_TIMEOUT] = timeout_q;
				rd_data[`FPC_ST_LAST_ALT] = prev_alt_q;
				rd_data[`FPC_ST_CNT_LO +: 16] = poll_cnt_q;
			end
			`FPC_REG_IRQ_STAT: rd_data[1:0] = istat_q;
			`FPC_REG_IRQ_MASK: rd_data[1:0] = imask_q;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// ==========================================
	// Microsecond tick for the poll limit
	assign tick = (div_q == 8'h00);
	always_comb begin
		div_d = tick ? (US_DIV - 8'h01) : (div_q - 8'h01);
	end

	// ==========================================
	// Sequencer
	assign poll_mode = (op_q == FPC_OP_POLL_DATA);
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		cyc_start_d = 1'b0;
		cyc_read_d = cyc_read_q;
		cyc_addr_d = cyc_addr_q;
		cyc_wdata_d = cyc_wdata_q;
		have_prev_d = have_prev_q;
		prev_alt_d = prev_alt_q;
		poll_cnt_d = poll_cnt_q;
		timeout_d = timeout_q;
		us_d = (tick && us_q != 24'h00_0000) ? (us_q - 24'h00_0001) : us_q;
		ev_done = 1'b0;
		ev_tmo = 1'b0;
		if (wr_en && wr_addr == `FPC_REG_ADDR) begin
			addr_d = 20'(merge({12'h000, addr_q}, wr_data, wr_strb));
		end
		if (wr_en && wr_addr == `FPC_REG_WDATA) begin
			wdata_d = 16'(merge({16'h0000, wdata_q}, wr_data, wr_strb));
		end
		unique case (st_q)
			FPC_SEQ_IDLE: begin
				if (wr_en && wr_addr == `FPC_REG_CTRL && wr_strb[0] && wr_data[`FPC_CTRL_GO]) begin
					op_d = fpc_op_e'(wr_data[`FPC_CTRL_OP_LO +: 3]);
					cyc_start_d = 1'b1;
					cyc_addr_d = addr_q;
					cyc_wdata_d = wdata_q;
					cyc_read_d = 1'b0;
					have_prev_d = 1'b0;
					poll_cnt_d = 16'h0000;
					timeout_d = 1'b0;
					us_d = POLL_LIMIT_US;
					st_d = FPC_SEQ_CMD;
					unique case (wr_data[`FPC_CTRL_OP_LO +: 3])
						FPC_OP_READ: cyc_read_d = 1'b1;
						FPC_OP_CHIP_ERASE: begin
							cyc_addr_d = `FPC_CHIP_ERASE_ADDR;
							cyc_wdata_d = `FPC_CHIP_ERASE_DATA;
						end
						FPC_OP_SECTOR_ERASE: cyc_wdata_d = `FPC_SECTOR_ERASE_DATA;
						FPC_OP_POLL_ALT, FPC_OP_POLL_DATA: begin
							cyc_read_d = 1'b1;
							st_d = FPC_SEQ_POLL;
						end
						default: begin
						end
					endcase
				end
			end
			FPC_SEQ_CMD: begin
				if (cyc_done) begin
					if (cyc_read_q) begin
						rdata_d = cyc_rdata;
					end
					if (op_q == FPC_OP_CHIP_ERASE || op_q == FPC_OP_SECTOR_ERASE) begin
						cyc_start_d = 1'b1;
						cyc_read_d = 1'b1;
						st_d = FPC_SEQ_POLL;
					end else begin
						st_d = FPC_SEQ_FIN;
					end
				end
			end
			FPC_SEQ_POLL: begin
				if (cyc_done) begin
					rdata_d = cyc_rdata;
					poll_cnt_d = poll_cnt_q + 16'h0001;
					prev_alt_d = cyc_rdata[`FPC_ALT_BIT];
					have_prev_d = 1'b1;
					// finish on match or still bit
					// in toggle mode a change, or a first read with no previous, counts as busy
					if (poll_mode ? (cyc_rdata[`FPC_POLL_BIT] == cyc_wdata_q[`FPC_POLL_BIT])
							: (have_prev_q && cyc_rdata[`FPC_ALT_BIT] == prev_alt_q)) begin
						st_d = FPC_SEQ_FIN;
					// give up after chip erase limit
					end else if (us_q == 24'h00_0000) begin
						timeout_d = 1'b1;
						ev_tmo = 1'b1;
						st_d = FPC_SEQ_IDLE;
					end else begin
						cyc_start_d = 1'b1;
					end
				end
			end
			FPC_SEQ_FIN: begin
				ev_done = 1'b1;
				st_d = FPC_SEQ_IDLE;
			end
		endcase
	end

	// ==========================================
	// Interrupt status, set wins over clear
	always_comb begin
		imask_d = imask_q;
		istat_d = istat_q;
		if (wr_en && wr_addr == `FPC_REG_IRQ_MASK && wr_strb[0]) begin
			imask_d = wr_data[1:0];
		end
		if (wr_en && wr_addr == `FPC_REG_IRQ_STAT && wr_strb[0]) begin
			istat_d = istat_q & ~wr_data[1:0];
		end
		istat_d[`FPC_IRQ_DONE] = istat_d[`FPC_IRQ_DONE] | ev_done;
		istat_d[`FPC_IRQ_TIMEOUT] = istat_d[`FPC_IRQ_TIMEOUT] | ev_tmo;
		irq_d = |(istat_d & imask_d);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= FPC_SEQ_IDLE;
			op_q <= FPC_OP_WRITE;
			addr_q <= `FPC_ADDR_RESET;
			wdata_q <= `FPC_DATA_RESET;
			rdata_q <= `FPC_DATA_RESET;
			cyc_start_q <= 1'b0;
			cyc_read_q <= 1'b0;
			cyc_addr_q <= `FPC_ADDR_RESET;
			cyc_wdata_q <= `FPC_DATA_RESET;
			have_prev_q <= 1'b0;
			prev_alt_q <= 1'b0;
			poll_cnt_q <= 16'h0000;
			timeout_q <= 1'b0;
			istat_q <= 2'b00;
			imask_q <= 2'b00;
			irq_q <= 1'b0;
			div_q <= 8'h00;
			us_q <= 24'h00_0000;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			cyc_start_q <= cyc_start_d;
			cyc_read_q <= cyc_read_d;
			cyc_addr_q <= cyc_addr_d;
			cyc_wdata_q <= cyc_wdata_d;
			have_prev_q <= have_prev_d;
			prev_alt_q <= prev_alt_d;
			poll_cnt_q <= poll_cnt_d;
			timeout_q <= timeout_d;
			istat_q <= istat_d;
			imask_q <= imask_d;
			irq_q <= irq_d;
			div_q <= div_d;
			us_q <= us_d;
		end
	end

	assign flash_addr = pins.addr;
	assign flash_dq_o = pins.dq;
	assign flash_dq_oe_n = pins.dq_oe_n;
	assign flash_ce_n = pins.ce_n;
	assign flash_oe_n = pins.oe_n;
	assign flash_we_n = pins.we_n;
	assign irq = irq_q;
endmodule

// File: core/fpc_defs.svh
// Constants for the flash polling controller: register map, fields, command codes, timing
//
// Operation
// - Alternating bit advances per read strobe; host toggles output enable.
// - Host holds one address for every poll read of a sequence.
// - Toggle polling relies only on change between reads, never on absolute values; data polling compares DQ7 with the written value.
// - Whole-chip erase final write uses address 5555.
// - Sector erase final write carries an address inside the sector.
// - Final erase write carries 10H for chip, 30H for sector.
// - Host holds output enable high while write and select low.
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

// ==========================================
// Register map (byte offsets)
`define FPC_REG_CTRL 8'h00
`define FPC_REG_ADDR 8'h04
`define FPC_REG_WDATA 8'h08
`define FPC_REG_RDATA 8'h0C
`define FPC_REG_STATUS 8'h10
`define FPC_REG_IRQ_STAT 8'h14
`define FPC_REG_IRQ_MASK 8'h18
`define FPC_REG_END 8'h1C

// ==========================================
// Fields
`define FPC_CTRL_GO 0
`define FPC_CTRL_OP_LO 1
`define FPC_IRQ_DONE 0
`define FPC_IRQ_TIMEOUT 1
`define FPC_ST_BUSY 0
`define FPC_ST_TIMEOUT 1
`define FPC_ST_LAST_ALT 2
`define FPC_ST_CNT_LO 16
`define FPC_POLL_BIT 7
`define FPC_ALT_BIT 6
`define FPC_ADDR_RESET 20'h0_0000
`define FPC_DATA_RESET 16'h0000

// ==========================================
// Command words
`define FPC_CHIP_ERASE_ADDR 20'h0_5555
`define FPC_CHIP_ERASE_DATA 16'h0010
`define FPC_SECTOR_ERASE_DATA 16'h0030

// ==========================================
// Timing
`define FPC_CLK_MHZ 100
`define FPC_T_AS_NS 10
`define FPC_T_WP_NS 100
`define FPC_T_WPH_NS 50
`define FPC_T_ACC_NS 70
`define FPC_T_OEHP_NS 150
`define FPC_SYNC_CYC 2
`define FPC_T_US_NS 1000
`define FPC_T_SECTOR_ERASE_MS 200
`define FPC_T_CHIP_ERASE_S 10
`define FPC_CYC(ns) ((((ns) * `FPC_CLK_MHZ) + 999) / 1000)
`define FPC_CHIP_ERASE_US (`FPC_T_CHIP_ERASE_S * 1000000)

`endif

// File: core/fpc_pkg.sv
// Types shared by the flash polling controller
package fpc_pkg;

	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] dq;
		logic dq_oe_n;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} fpc_pins_s;

	typedef enum logic [2:0] {
		FPC_OP_WRITE = 3'h0,
		FPC_OP_READ = 3'h1,
		FPC_OP_CHIP_ERASE = 3'h2,
		FPC_OP_SECTOR_ERASE = 3'h3,
		FPC_OP_POLL_ALT = 3'h4,
		FPC_OP_POLL_DATA = 3'h5
	} fpc_op_e;

	typedef enum logic [1:0] {
		FPC_CYC_IDLE = 2'b00,
		FPC_CYC_SETUP = 2'b01,
		FPC_CYC_STROBE = 2'b11,
		FPC_CYC_RECOV = 2'b10
	} fpc_cyc_e;

	typedef enum logic [1:0] {
		FPC_SEQ_IDLE = 2'b00,
		FPC_SEQ_CMD = 2'b01,
		FPC_SEQ_POLL = 2'b11,
		FPC_SEQ_FIN = 2'b10
	} fpc_seq_e;

endpackage

// File: core/fpc_bus_cycle.sv
// One flash bus cycle: a write strobe or a read strobe with recovery
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_bus_cycle (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Request
	input wire logic start,
	input wire logic is_read,
	input wire logic [19:0] addr,
	input wire logic [15:0] wdata,
	output logic done,
	output logic [15:0] rdata,
	// Flash pins
	output fpc_pkg::fpc_pins_s pins,
	input wire logic [15:0] dq_i
);
	import fpc_pkg::*;

	localparam logic [7:0] SETUP_CYC = 8'(`FPC_CYC(`FPC_T_AS_NS));
	localparam logic [7:0] WP_CYC = 8'(`FPC_CYC(`FPC_T_WP_NS));
	localparam logic [7:0] WPH_CYC = 8'(`FPC_CYC(`FPC_T_WPH_NS));
	localparam logic [7:0] ACC_CYC = 8'(`FPC_CYC(`FPC_T_ACC_NS) + `FPC_SYNC_CYC + 1);
	localparam logic [7:0] OEHP_CYC = 8'(`FPC_CYC(`FPC_T_OEHP_NS));

	fpc_cyc_e st_q, st_d;
	logic [7:0] cnt_q, cnt_d;
	logic rd_q, rd_d;
	logic done_q, done_d;
	logic [15:0] rdata_q, rdata_d;
	fpc_pins_s pins_q, pins_d;
	logic [15:0] dq_s1_q, dq_s2_q;

	// ==========================================
	// Data pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end else begin
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	// ==========================================
	// Strobe sequencer
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		rd_d = rd_q;
		done_d = 1'b0;
		rdata_d = rdata_q;
		pins_d = pins_q;
		unique case (st_q)
			FPC_CYC_IDLE: begin
				pins_d.ce_n = 1'b1;
				pins_d.oe_n = 1'b1;
				pins_d.we_n = 1'b1;
				pins_d.dq_oe_n = 1'b1;
				if (start) begin
					st_d = FPC_CYC_SETUP;
					cnt_d = SETUP_CYC;
					rd_d = is_read;
					pins_d.addr = addr;
					pins_d.dq = wdata;
					pins_d.ce_n = 1'b0;
					pins_d.dq_oe_n = is_read;
				end
			end
			FPC_CYC_SETUP: begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					st_d = FPC_CYC_STROBE;
					cnt_d = rd_q ? ACC_CYC : WP_CYC;
					// oe stays high while we low
					pins_d.we_n = rd_q;
					pins_d.oe_n = !rd_q;
				end
			end
			FPC_CYC_STROBE: begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					st_d = FPC_CYC_RECOV;
					cnt_d = rd_q ? OEHP_CYC : WPH_CYC;
					if (rd_q) begin
						rdata_d = dq_s2_q;
					end
					pins_d.we_n = 1'b1;
					pins_d.oe_n = 1'b1;
					pins_d.ce_n = 1'b1;
				end
			end
			FPC_CYC_RECOV: begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					st_d = FPC_CYC_IDLE;
					done_d = 1'b1;
					pins_d.dq_oe_n = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= FPC_CYC_IDLE;
			cnt_q <= 8'h00;
			rd_q <= 1'b0;
			done_q <= 1'b0;
			rdata_q <= 16'h0000;
			pins_q <= '{addr: 20'h0_0000, dq: 16'h0000, dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			rd_q <= rd_d;
			done_q <= done_d;
			rdata_q <= rdata_d;
			pins_q <= pins_d;
		end
	end

	assign done = done_q;
	assign rdata = rdata_q;
	assign pins = pins_q;
endmodule

// File: core/fpc_axil.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_axil (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register side
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data
);
	import fpc_pkg::*;

	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, wr_en_q, wr_en_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a < `FPC_REG_END);
	endfunction

	// ==========================================
	// Write and read channels
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		wr_en_d = 1'b0;
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (aw_have_q && w_have_q && !bvalid_q) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			wr_en_d = mapped(awaddr_q);
			bresp_d = mapped(awaddr_q) ? 2'b00 : 2'b10;
		end
		awready_d = !aw_have_d;
		wready_d = !w_have_d;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rdata_d = mapped(s_axi_araddr) ? rd_data : 32'h0000_0000;
			rresp_d = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'b00;
			wr_en_q <= 1'b0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'b00;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			wr_en_q <= wr_en_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wr_en = wr_en_q;
	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign wr_strb = wstrb_q;
	assign rd_addr = s_axi_araddr;
endmodule

// File: testbench/fpc_host_props.sv
// Port-level checks for the flash host controller
`timescale 1ns/1ps
module fpc_host_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI read
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Flash pins
	input wire logic [19:0] flash_addr,
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_dq_oe_n,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_write_oe_high: assert property (
		!flash_we_n |-> flash_oe_n && !flash_ce_n && !flash_dq_oe_n) else $error("oe low in write");
	a_write_ten_low: assert property (
		$fell(flash_we_n) |-> !flash_we_n[*8] ##1 !flash_we_n ##1 !flash_we_n ##1 flash_we_n)
		else $error("write pulse width");
	a_chip_addr: assert property (
		$fell(flash_we_n) && flash_dq_o == 16'h0010 |-> flash_addr == 20'h0_5555) else $error("chip erase addr");
	a_write_held: assert property (
		$past(!flash_we_n) && !flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_o))
		else $error("write moved");
	a_read_quiet: assert property (
		!flash_oe_n |-> flash_dq_oe_n && !flash_ce_n && flash_we_n) else $error("read drives dq");
	a_read_ten_low: assert property (
		$fell(flash_oe_n) |-> !flash_oe_n[*8] ##1 !flash_oe_n ##1 !flash_oe_n ##1 flash_oe_n)
		else $error("read strobe width");
	a_strobe_gap: assert property (
		$rose(flash_oe_n) |-> flash_oe_n[*8] ##1 flash_oe_n[*7]) else $error("strobe high short");
	a_addr_fixed: assert property (
		$past(!flash_ce_n) && !flash_ce_n |-> $stable(flash_addr)) else $error("addr moved");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");

	c_sector: cover property ($fell(flash_we_n) && flash_dq_o == 16'h0030);
	c_chip: cover property ($fell(flash_we_n) && flash_dq_o == 16'h0010);
	c_poll: cover property ($rose(flash_oe_n));
endmodule

bind fpc_host fpc_host_props fpc_host_props_i (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
	.flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// File: testbench/fpc_flash_model.sv
// Behavioural dual-plane flash with status bits
`timescale 1ns/1ps
module fpc_flash_model #(
	parameter int PROG_NS = 3000,
	parameter int SECT_NS = 20000,
	parameter int CHIP_NS = 30000
) (
	// Pins
	input wire logic [19:0] addr,
	input wire logic [15:0] dq_in,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	output logic [15:0] dq_out,
	// Bench control
	input wire logic hang
);
	logic [15:0] mem [256];
	logic [15:0] wr_q;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] rd;
	logic [7:0] wa_q;
	logic busy_q = 1'b0;
	logic erase_q = 1'b0;
	logic plane_q = 1'b0;
	logic tog_q = 1'b0;
	logic strobe_off;

	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
	end

	task automatic finish(input int t);
		#t;
		wait (!hang);
		if (erase_q) begin
			foreach (mem[i]) mem[i] = 16'hFFFF;
		end else begin
			mem[wa_q] = wr_q;
		end
		busy_q = 1'b0;
	endtask

	always @(negedge we_n) begin
		if (!ce_n && !busy_q && dq_in != 16'h00AA && dq_in != 16'h0055 && dq_in != 16'h0080
				&& dq_in != 16'h00A0) begin
			wr_q = dq_in;
			wa_q = addr[7:0];
			plane_q = addr[19];
			erase_q = (dq_in == 16'h0030) || (dq_in == 16'h0010 && addr == 20'h0_5555);
			busy_q = 1'b1;
			fork
				finish(dq_in == 16'h0010 ? CHIP_NS : erase_q ? SECT_NS : PROG_NS);
			join_none
		end
	end

	// toggle advances once per read strobe while busy, even when both strobes rise together
	assign strobe_off = oe_n | ce_n;
	always @(posedge strobe_off) begin
		if (busy_q) begin
			tog_q <= !tog_q;
		end
	end

	always @* begin
		rd = mem[addr[7:0]];
		if (busy_q && addr[19] == plane_q) begin
			rd[7] = erase_q ? 1'b0 : !wr_q[7];
			rd[6] = tog_q;
			rd[2] = erase_q ? tog_q : 1'b1;
		end
	end

	// Released bus shows inverse of last value
	always @(posedge oe_n) last_q <= rd;
	assign dq_out = (!ce_n && !oe_n) ? rd : ~last_q;
endmodule

// File: testbench/fpc_host_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_host_tb;
	import fpc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic hang = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, dq_oe_n, ce_n, oe_n, we_n, irq;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic [19:0] faddr, pa;
	logic [15:0] dq_o, dq_i;
	int err_total = 0;
	int checks = 0;

	always #5 aclk = ~aclk;

	fpc_host #(.POLL_LIMIT_US(24'h00_0032)) fpc_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.flash_addr(faddr), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_i), .flash_ce_n(ce_n),
		.flash_oe_n(oe_n), .flash_we_n(we_n), .irq(irq));
	fpc_flash_model fpc_flash_model_i (.addr(faddr), .dq_in(dq_o), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.dq_out(dq_i), .hang(hang));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rdreg(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic op(input fpc_op_e o, input logic [19:0] a, input logic [15:0] d);
		wr(`FPC_REG_ADDR, {12'h000, a});
		wr(`FPC_REG_WDATA, {16'h0000, d});
		wr(`FPC_REG_CTRL, {28'h000_0000, o, 1'b1});
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0) rdreg(`FPC_REG_STATUS);
	endtask

	task automatic unlock(input logic [15:0] c);
		op(FPC_OP_WRITE, 20'h0_5555, 16'h00AA);
		op(FPC_OP_WRITE, 20'h0_2AAA, 16'h0055);
		op(FPC_OP_WRITE, 20'h0_5555, c);
	endtask

	task automatic erase_pre();
		unlock(16'h0080);
		op(FPC_OP_WRITE, 20'h0_5555, 16'h00AA);
		op(FPC_OP_WRITE, 20'h0_2AAA, 16'h0055);
	endtask

	initial begin
		#500_000;
		err_total++;
		summarize();
	end

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdreg(`FPC_REG_CTRL);
		chk(rd, 32'h0000_0000);
		rdreg(`FPC_REG_END);
		chk({rd[31:2], rsp}, 32'h0000_0002);
		wr(`FPC_REG_END, 32'hFFFF_FFFF);
		chk(rsp, 2'h2);
		wr(`FPC_REG_IRQ_MASK, 32'h0000_0003);
		$display("test registers done");
		for (int k = 0; k < 2; k++) begin
			pa = k ? 20'h8_0010 : 20'h0_0010;
			unlock(16'h00A0);
			op(FPC_OP_WRITE, pa, 16'h1234);
			op(FPC_OP_READ, pa ^ 20'h8_0000, 16'h0000);
			rdreg(`FPC_REG_RDATA);
			chk(rd[15:0], 16'hFFFF);
			op(k ? FPC_OP_POLL_ALT : FPC_OP_POLL_DATA, pa, 16'h1234);
			chk(rd[31:16] > (k ? 16'h0002 : 16'h0001), 1'b1);
			chk(irq, 1'b1);
			wr(`FPC_REG_IRQ_STAT, 32'h0000_0001);
			rdreg(`FPC_REG_IRQ_STAT);
			chk(rd, 32'h0000_0000);
			chk(irq, 1'b0);
			op(FPC_OP_READ, pa, 16'h0000);
			rdreg(`FPC_REG_RDATA);
			chk(rd[15:0], 16'h1234);
			erase_pre();
			op(k ? FPC_OP_CHIP_ERASE : FPC_OP_SECTOR_ERASE, pa, 16'h0000);
			chk(rd[31:16] > 16'h0002, 1'b1);
			chk(rd[1], 1'b0);
			rdreg(`FPC_REG_IRQ_STAT);
			chk(rd, 32'h0000_0001);
			wr(`FPC_REG_IRQ_STAT, 32'h0000_0001);
			op(FPC_OP_READ, pa, 16'h0000);
			rdreg(`FPC_REG_RDATA);
			chk(rd[15:0], 16'hFFFF);
			$display("test program and erase %0d done", k);
		end
		hang <= 1'b1;
		erase_pre();
		wr(`FPC_REG_IRQ_STAT, 32'h0000_0001);
		op(FPC_OP_SECTOR_ERASE, 20'h0_0010, 16'h0000);
		chk(rd[1], 1'b1);
		rdreg(`FPC_REG_IRQ_STAT);
		chk(rd, 32'h0000_0002);
		chk(irq, 1'b1);
		hang <= 1'b0;
		$display("test poll timeout done");
		summarize();
	end
endmodule
